/* slpc_pkg.sv */
// Constants and carrier types for the loss-pulse and clock-output control block.
// Assumes a single 20 MHz clock domain and an active-low asynchronous reset.
//
// Functional notes
// - Strap bit 0 selects fiber-module emulation mode
// - Loss indication active high on link drop
// - Two-bit field selects loss indication behaviour
// - Field 00 holds loss indication low
// - Field 01 gives one 20 ms pulse
// - Field 10 gives one 200 ms pulse
// - Field 11 gives one 500 ms pulse
// - Both reference clock outputs enabled after reset
// - Writing 0 to enable bits disables clocks
// - Micro clock 4 MHz, 125 MHz by bit/strap
// - Pll strap 1 takes chained 125 MHz reference
// - Straps captured when leaving reset
package slpc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned PULSE_SHORT_MS = 20;
    localparam int unsigned PULSE_MID_MS = 200;
    localparam int unsigned PULSE_LONG_MS = 500;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_MS * CYC_PER_MS;
    localparam int unsigned PULSE_MID_CYC = PULSE_MID_MS * CYC_PER_MS;
    localparam int unsigned PULSE_LONG_CYC = PULSE_LONG_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 24;

    // ----------------------------------------------------------------
    // Reset values and field codes
    // ----------------------------------------------------------------
    localparam logic [1:0] LOSS_MODE_RESET = 2'h0;
    localparam logic CLK_EN_RESET = 1'h1;
    localparam logic MICRO_FAST_RESET = 1'h0;
    localparam int unsigned STRAP_SFP_BIT = 0;
    localparam int unsigned STRAP_CLK_BIT = 1;
    localparam int unsigned STRAP_W = 8;

    typedef enum logic [1:0] {
        SLPC_LOSS_OFF = 2'b00,
        SLPC_LOSS_20MS = 2'b01,
        SLPC_LOSS_200MS = 2'b10,
        SLPC_LOSS_500MS = 2'b11
    } slpc_loss_mode_e;

    // Straps caught as the device leaves reset
    typedef struct packed {
        logic pll_source_select;
        logic eeprom_data;
        logic [STRAP_W-1:0] config_strap;
    } slpc_straps_s;

    // Clock output controls
    typedef struct packed {
        logic ref_clk_enable;
        logic micro_clk_enable;
        logic micro_clk_fast;
    } slpc_clk_ctrl_s;

endpackage

/* slpc_loss_clock_ctrl.sv */
// Loss-of-signal pulse generator and reference clock output control.
// Assumes link_up comes from logic on clk; strap pins and the chain clock
// select are asynchronous and synchronised here; settings come from a
// management block on the same clock.
// Assumes the board holds the strap pins steady for a few clocks after
// reset is released, and pulls the loss line low while it is not driven.
`timescale 1ns/100ps
module slpc_loss_clock_ctrl #(
    parameter int unsigned PULSE_SHORT_CYC = slpc_pkg::PULSE_SHORT_CYC,
    parameter int unsigned PULSE_MID_CYC = slpc_pkg::PULSE_MID_CYC,
    parameter int unsigned PULSE_LONG_CYC = slpc_pkg::PULSE_LONG_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Strap pins
    input wire logic pll_source_select_pin,
    input wire logic eeprom_data_pin,
    input wire logic [slpc_pkg::STRAP_W-1:0] config_strap_pin,
    // Link status
    input wire logic link_up,
    // Management settings
    input wire logic [1:0] loss_mode,
    input wire logic ref_clk_en_wr,
    input wire logic ref_clk_en_data,
    input wire logic micro_clk_en_wr,
    input wire logic micro_clk_en_data,
    input wire logic micro_fast_wr,
    input wire logic micro_fast_data,
    // Loss indication pin
    output logic rx_loss_indication,
    output logic rx_loss_oe,
    // Clock control and status
    output slpc_pkg::slpc_clk_ctrl_s clk_ctrl,
    output logic pll_use_chain_ref,
    output slpc_pkg::slpc_straps_s straps,
    output logic loss_busy
);

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // The synchroniser is cleared by reset, so the pins only reach
    // strap_sync on the second edge after release; capture waits for that.
    // The cost is three clocks of copper behaviour after every reset.
    localparam int SW = slpc_pkg::STRAP_W + 2;
    logic [SW-1:0] strap_meta;
    logic [SW-1:0] strap_sync;
    logic strap_taken;
    logic [1:0] rel_cnt;
    logic straps_valid;
    logic sfp_mode;
    logic micro_strap_fast;

    // One strap bit, forced low until the captured set can be trusted
    function automatic logic strap_bit(
        input logic valid,
        input slpc_pkg::slpc_straps_s caught,
        input logic [2:0] pos
    );
        strap_bit = valid && caught.config_strap[pos];
    endfunction

    // Two-flop synchroniser on the strap pins; only strap_sync is read
    // further on, since strap_meta may still be settling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta <= {pll_source_select_pin, eeprom_data_pin, config_strap_pin};
            strap_sync <= strap_meta;
        end
    end

    // Catch straps once, when the synchroniser has filled after release;
    // later pin changes are ignored until the next reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_taken <= 1'b0;
            straps <= '0;
        end else if (!strap_taken && rel_cnt == 2'h2) begin
            strap_taken <= 1'b1;
            straps <= strap_sync;
        end
    end

    // Count the edges since release; the sync pipe is full once it reads 2
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rel_cnt <= 2'h0;
        end else if (rel_cnt != 2'h3) begin
            rel_cnt <= rel_cnt + 2'h1;
        end
    end

    // Straps are trusted from the edge on which they are caught
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            straps_valid <= 1'b0;
        end else if (rel_cnt == 2'h2) begin
            straps_valid <= 1'b1;
        end
    end

    // Fiber emulation when the select strap reads 0; copper until then
    assign sfp_mode = straps_valid
        && !strap_bit(straps_valid, straps, 3'(slpc_pkg::STRAP_SFP_BIT));

    // Either the fast bit or this strap picks 125 MHz for the micro output
    assign micro_strap_fast =
        strap_bit(straps_valid, straps, 3'(slpc_pkg::STRAP_CLK_BIT));

    // ----------------------------------------------------------------
    // Loss pulse
    // ----------------------------------------------------------------
    // The loss mode is sampled only on the edge that takes the drop, so a
    // later change of the field cannot stretch or cut a running pulse.
    // A drop seen while the field is 00 is not remembered for later.
    logic link_up_d;
    logic [slpc_pkg::CNT_W-1:0] pulse_cnt;
    logic link_drop;
    logic pulse_running;

    // Link drop is the falling edge of link_up; the delayed copy resets low
    // so a link that is already down at release gives no false drop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link_up_d <= 1'b0;
        end else begin
            link_up_d <= link_up;
        end
    end
    assign link_drop = link_up_d && !link_up;

    // Counter state shared by the load, the pin and the busy flag
    assign pulse_running = pulse_cnt != '0;

    // Pulse length in clocks for each loss mode; the longest must fit in
    // CNT_W bits, which holds 500 ms at 20 MHz with room to spare
    function automatic logic [slpc_pkg::CNT_W-1:0] pulse_len(input logic [1:0] mode);
        unique case (slpc_pkg::slpc_loss_mode_e'(mode))
            slpc_pkg::SLPC_LOSS_20MS: pulse_len = slpc_pkg::CNT_W'(PULSE_SHORT_CYC);
            slpc_pkg::SLPC_LOSS_200MS: pulse_len = slpc_pkg::CNT_W'(PULSE_MID_CYC);
            slpc_pkg::SLPC_LOSS_500MS: pulse_len = slpc_pkg::CNT_W'(PULSE_LONG_CYC);
            slpc_pkg::SLPC_LOSS_OFF: pulse_len = '0;
        endcase
    endfunction

    // Count down the pulse; a drop mid-pulse is ignored so the width stays honest
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_cnt <= '0;
        end else if (pulse_running) begin
            pulse_cnt <= pulse_cnt - slpc_pkg::CNT_W'(1);
        end else if (link_drop && sfp_mode) begin
            pulse_cnt <= pulse_len(loss_mode);
        end
    end

    // Pin high for as many clocks as the counter runs, one clock behind it; mode 00 never loads it, so
    // the pin stays low in that mode whatever the link does
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_loss_indication <= 1'b0;
            rx_loss_oe <= 1'b0;
        end else begin
            rx_loss_indication <= sfp_mode && pulse_running;
            rx_loss_oe <= sfp_mode;
        end
    end

    // Busy flag for the management side, one clock behind the counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loss_busy <= 1'b0;
        end else begin
            loss_busy <= pulse_running;
        end
    end

    // ----------------------------------------------------------------
    // Reference clock control
    // ----------------------------------------------------------------
    // These are control levels only; the clock gating and the divider for
    // the micro output sit outside this block and must switch glitch-free.
    logic micro_fast_bit;

    // Enables default on; software writes 0 to turn outputs off. All three
    // fields share one process so the output struct has a single driver.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_ctrl.ref_clk_enable <= slpc_pkg::CLK_EN_RESET;
            clk_ctrl.micro_clk_enable <= slpc_pkg::CLK_EN_RESET;
            clk_ctrl.micro_clk_fast <= slpc_pkg::MICRO_FAST_RESET;
        end else begin
            clk_ctrl.micro_clk_fast <= micro_fast_bit || micro_strap_fast;
            if (ref_clk_en_wr) begin
                clk_ctrl.ref_clk_enable <= ref_clk_en_data;
            end
            if (micro_clk_en_wr) begin
                clk_ctrl.micro_clk_enable <= micro_clk_en_data;
            end
        end
    end

    // Software copy of the fast select; it reaches the output one clock later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            micro_fast_bit <= slpc_pkg::MICRO_FAST_RESET;
        end else if (micro_fast_wr) begin
            micro_fast_bit <= micro_fast_data;
        end
    end

    // Chained reference follows the captured strap; it cannot change until
    // the next reset, which keeps the PLL source stable while running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_use_chain_ref <= 1'b0;
        end else begin
            pll_use_chain_ref <= straps_valid && straps.pll_source_select;
        end
    end

endmodule

/* slpc_assertions.sv */
// Port checker for the loss-pulse and clock-output control block.
// Assumes it is bound to slpc_loss_clock_ctrl with the same pulse lengths.
`timescale 1ns/100ps
module slpc_assertions #(
    parameter int unsigned PULSE_SHORT_CYC = 20,
    parameter int unsigned PULSE_MID_CYC = 200,
    parameter int unsigned PULSE_LONG_CYC = 500
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Inputs
    input wire logic link_up,
    input wire logic [1:0] loss_mode,
    input wire logic ref_clk_en_wr,
    input wire logic ref_clk_en_data,
    input wire logic micro_clk_en_wr,
    input wire logic micro_clk_en_data,
    input wire logic micro_fast_wr,
    input wire logic micro_fast_data,
    // Outputs
    input wire logic rx_loss_indication,
    input wire logic rx_loss_oe,
    input wire slpc_pkg::slpc_clk_ctrl_s clk_ctrl,
    input wire logic pll_use_chain_ref,
    input wire slpc_pkg::slpc_straps_s straps,
    input wire logic loss_busy
);
    // ----------------------------------------------------------------
    // Helper logic and properties
    // ----------------------------------------------------------------
    logic [23:0] hi_n;
    logic [1:0] pm;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Length of the running high level; a reset mid-pulse leaves it zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_n <= 24'h0;
        end else begin
            hi_n <= rx_loss_indication ? hi_n + 24'h1 : 24'h0;
        end
    end
    // Mode taken at the drop edge, two edges before busy is seen high
    always_ff @(posedge clk) begin
        if ($rose(loss_busy)) begin
            pm <= $past(loss_mode, 2);
        end
    end
    a_oe_fiber_only: assert property (rx_loss_oe |-> !straps.config_strap[0])
        else $error("loss pin driven outside fiber mode");
    a_rise_after_drop: assert property (
        $rose(rx_loss_indication) |-> !$past(link_up, 2) && $past(link_up, 3))
        else $error("loss pulse without a link drop");
    a_busy_needs_mode: assert property (
        $rose(loss_busy) |-> $past(loss_mode, 2) != 2'h0 && rx_loss_oe)
        else $error("pulse started while loss mode off");
    a_pulse_width: assert property (
        $fell(rx_loss_indication) && hi_n != 24'h0 |-> hi_n == (pm == 2'h1 ?
        PULSE_SHORT_CYC : pm == 2'h2 ? PULSE_MID_CYC : PULSE_LONG_CYC))
        else $error("loss pulse of wrong length");
    a_pin_within_busy: assert property (rx_loss_indication |-> loss_busy)
        else $error("loss pin high with counter idle");
    a_ref_write: assert property (
        ref_clk_en_wr |=> clk_ctrl.ref_clk_enable == $past(ref_clk_en_data))
        else $error("reference clock enable not written");
    a_micro_write: assert property (
        micro_clk_en_wr |=> clk_ctrl.micro_clk_enable == $past(micro_clk_en_data))
        else $error("micro clock enable not written");
    a_fast_write: assert property (
        micro_fast_wr && micro_fast_data ##1 !micro_fast_wr |-> ##1 clk_ctrl.micro_clk_fast)
        else $error("micro clock not fast after write");
    a_fast_strap: assert property (straps.config_strap[1] |-> ##4 clk_ctrl.micro_clk_fast)
        else $error("micro clock not fast with strap set");
    a_chain_ref: assert property (pll_use_chain_ref |-> straps.pll_source_select)
        else $error("chained reference without strap");
    c_pulse: cover property ($fell(rx_loss_indication));
    c_ref_off: cover property (ref_clk_en_wr && !ref_clk_en_data);
    c_chain: cover property (pll_use_chain_ref);
endmodule

/* slpc_host_model.sv */
// Host board receiver of the loss pin: measures every high run.
// Assumes a board pull-down holds the line low while it is not driven.
`timescale 1ns/100ps
module slpc_host_model (
    // Clock and line
    input wire logic clk,
    input wire logic loss_line,
    // Measured pulse
    output logic done,
    output logic [23:0] width
);
    logic [23:0] run = 24'h0;
    // Report a run once the line is low again; the host only listens
    always @(posedge clk) begin
        done <= !loss_line && run != 24'h0;
        if (loss_line) begin
            run <= run + 24'h1;
        end else if (run != 24'h0) begin
            width <= run;
            run <= 24'h0;
        end
    end
endmodule

/* tb_top.sv */
// Self-checking bench for the loss-pulse and clock-output control block.
// Assumes short pulse lengths by parameter and one 20 MHz clock.
`timescale 1ns/100ps
module tb_top;
    // ----------------------------------------------------------------
    // Stimulus, scoreboard and checks
    // ----------------------------------------------------------------
    localparam int NS = 6;
    localparam int NM = 9;
    localparam int NL = 12;
    logic clk = 1'b0, reset_n = 1'b0, pll_pin = 1'b0, ee_pin = 1'b0, link_up = 1'b1;
    logic [7:0] cfg = 8'h0;
    logic [1:0] mode = 2'h0;
    logic [5:0] wr = 6'h0; // Ref, micro enable and fast: strobe then data
    logic [5:0] v;
    logic loss, oe, chain, busy, done;
    logic [23:0] width;
    slpc_pkg::slpc_clk_ctrl_s ctl;
    slpc_pkg::slpc_straps_s st;
    int bad_count = 0;
    int n_checks = 0;
    int exp_q[$];
    initial forever #25 clk = ~clk;
    slpc_loss_clock_ctrl #(.PULSE_SHORT_CYC(NS), .PULSE_MID_CYC(NM), .PULSE_LONG_CYC(NL)) dut_u (
        .clk(clk), .reset_n(reset_n), .pll_source_select_pin(pll_pin), .eeprom_data_pin(ee_pin),
        .config_strap_pin(cfg), .link_up(link_up), .loss_mode(mode), .ref_clk_en_wr(wr[5]),
        .ref_clk_en_data(wr[4]), .micro_clk_en_wr(wr[3]), .micro_clk_en_data(wr[2]),
        .micro_fast_wr(wr[1]), .micro_fast_data(wr[0]), .rx_loss_indication(loss),
        .rx_loss_oe(oe), .clk_ctrl(ctl), .pll_use_chain_ref(chain), .straps(st), .loss_busy(busy));
    // Board line: undriven pin is pulled low
    slpc_host_model host_u (.clk(clk), .loss_line(oe ? loss : 1'b0), .done(done), .width(width));
    function automatic int plen(input logic [1:0] m);
        return m == 2'h1 ? NS : m == 2'h2 ? NM : m == 2'h3 ? NL : 0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Straps held steady across release, as the synchroniser needs
    task automatic rst(input logic p, input logic [7:0] c);
        reset_n <= 1'b0;
        pll_pin <= p;
        cfg <= c;
        ee_pin <= 1'($urandom);
        repeat (3) @(posedge clk);
        chk(ctl, 3'b110);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(st, {p, ee_pin, c});
        chk({chain, oe, ctl.micro_clk_fast}, {p, !c[0], c[1]});
    endtask
    // One link drop; only a fresh drop in fiber mode is noted as a pulse
    task automatic drop(input logic [1:0] m, input bit fresh);
        mode <= m;
        @(posedge clk);
        link_up <= 1'b0;
        if (fresh && !cfg[0] && plen(m) != 0) exp_q.push_back(plen(m));
        repeat (2) @(posedge clk);
        link_up <= 1'b1;
        @(posedge clk);
        chk(busy, fresh ? (!cfg[0] && plen(m) != 0) : 1'b1);
    endtask
    // Each measured pulse is matched against the oldest note
    always @(posedge clk) begin
        if (done === 1'b1) chk(width, exp_q.size() ? exp_q.pop_front() : 0);
    end
    initial begin
        void'($urandom(32'hb82b));
        rst(1'b1, {6'($urandom), 2'b11});
        drop(2'h1, 1'b1);
        repeat (NL + 6) @(posedge clk);
        $display("test copper strap mode done");
        rst(1'b0, {6'($urandom), 2'b00});
        for (int i = 0; i < 8; i++) begin
            drop(i < 4 ? 2'(i) : 2'($urandom), 1'b1);
            if (i == 3) drop(2'h1, 1'b0);
            repeat (NL + 6) @(posedge clk);
        end
        $display("test loss pulses done");
        for (int i = 0; i < 8; i++) begin
            v = 6'($urandom);
            wr <= {1'b1, v[0], 1'b1, v[1], 1'b1, v[2]};
            @(posedge clk);
            wr <= 6'h0;
            repeat (3) @(posedge clk);
            chk(ctl, {v[0], v[1], v[2]});
        end
        $display("test clock writes done");
        chk(exp_q.size(), 0);
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
bind slpc_loss_clock_ctrl slpc_assertions #(
    .PULSE_SHORT_CYC(PULSE_SHORT_CYC),
    .PULSE_MID_CYC(PULSE_MID_CYC),
    .PULSE_LONG_CYC(PULSE_LONG_CYC)
) chk_u (
    .clk(clk),
    .reset_n(reset_n),
    .link_up(link_up),
    .loss_mode(loss_mode),
    .ref_clk_en_wr(ref_clk_en_wr),
    .ref_clk_en_data(ref_clk_en_data),
    .micro_clk_en_wr(micro_clk_en_wr),
    .micro_clk_en_data(micro_clk_en_data),
    .micro_fast_wr(micro_fast_wr),
    .micro_fast_data(micro_fast_data),
    .rx_loss_indication(rx_loss_indication),
    .rx_loss_oe(rx_loss_oe),
    .clk_ctrl(clk_ctrl),
    .pll_use_chain_ref(pll_use_chain_ref),
    .straps(straps),
    .loss_busy(loss_busy)
);
